// [rtl/matrix_setup_pkg.sv]
package matrix_setup_pkg;

  localparam int SETUP_W = 7;
  localparam int MAX_SETUP = 100;
  localparam int FMT_W = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ROW_W = 3;
  localparam int COL_W = 9;
  localparam int SYNC_STAGES = 2;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [ADDR_W-1:0] EDIT_PTR_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] TRIG_EN_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] RB_FORMAT_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] CONTROL_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] TRIG_INDEX_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h14;

  // Field positions.
  localparam int CTRL_RESTORE_BIT = 0;
  localparam int CTRL_CLR_REJECT_BIT = 1;
  localparam int STAT_REJECT_BIT = 0;
  localparam int STAT_STYLE_LSB = 1;
  localparam int STAT_PER_TALK_BIT = 3;
  localparam int STAT_CLOSED_BIT = 4;

  // Reset and default values.
  localparam logic [SETUP_W-1:0] EDIT_PTR_RST = 7'h00;
  localparam logic [SETUP_W-1:0] LIVE_SETUP = 7'h00;
  localparam logic [SETUP_W-1:0] TRIG_INDEX_RST = 7'h00;
  localparam logic TRIG_EN_RST = 1'b0;
  localparam logic [FMT_W-1:0] RB_FORMAT_RST = 3'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Characters of the readback encodings.
  localparam logic [7:0] CHAR_OPEN = 8'h2D;
  localparam logic [7:0] CHAR_CLOSED = 8'h58;
  localparam logic [7:0] CHAR_ROW_A = 8'h41;
  localparam logic [7:0] CHAR_DIGIT_0 = 8'h30;
  localparam logic [7:0] CHAR_HEX_BASE = 8'h37;

  typedef enum logic [1:0] {
    STYLE_FULL = 2'b00,
    STYLE_INSPECT = 2'b01,
    STYLE_CONDENSED = 2'b10,
    STYLE_BINARY = 2'b11
  } rb_style_t;

  function automatic rb_style_t style_of(input logic [FMT_W-1:0] fmt);
    return rb_style_t'(fmt[2:1]);
  endfunction : style_of

  function automatic logic [7:0] hex_char(input logic [3:0] nib);
    return (nib < 4'hA) ? 8'(CHAR_DIGIT_0 + {4'h0, nib}) : 8'(CHAR_HEX_BASE + {4'h0, nib});
  endfunction : hex_char

endpackage : matrix_setup_pkg

// [rtl/trig_edge_sync.sv]
`timescale 1ns/10ps
module trig_edge_sync #(
  parameter int STAGES = matrix_setup_pkg::SYNC_STAGES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic async_in,
  output logic rise
);

  if (STAGES < 2) begin : g_bad
    $error("trig_edge_sync needs at least two stages");
  end

  typedef struct packed {
    logic [STAGES-1:0] chain;
    logic prev;
  } sync_t;

  sync_t s;
  sync_t n;

  // Only the last chain stage feeds the edge detector.
  always_comb begin
    n = s;
    n.chain = {s.chain[STAGES-2:0], async_in};
    n.prev = s.chain[STAGES-1];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign rise = s.chain[STAGES-1] & ~s.prev;

endmodule : trig_edge_sync

// [rtl/matrix_setup_ctrl.sv]
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
module matrix_setup_ctrl #(
  parameter int MAX_SETUP = matrix_setup_pkg::MAX_SETUP
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [matrix_setup_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [matrix_setup_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [matrix_setup_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [matrix_setup_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic dev_clear,
  input wire logic bus_trigger,
  input wire logic ext_trigger_pin,
  input wire logic xp_valid,
  input wire logic xp_close,
  input wire logic [matrix_setup_pkg::ROW_W-1:0] xp_row,
  input wire logic [matrix_setup_pkg::COL_W-1:0] xp_col,
  output logic relay_we,
  output logic mem_we,
  output logic [matrix_setup_pkg::SETUP_W-1:0] xp_setup,
  output logic [matrix_setup_pkg::ROW_W-1:0] xp_row_out,
  output logic [matrix_setup_pkg::COL_W-1:0] xp_col_out,
  output logic xp_close_out,
  output logic recall_stb,
  output logic [matrix_setup_pkg::SETUP_W-1:0] recall_setup,
  input wire logic setup_readback_query,
  input wire logic [matrix_setup_pkg::SETUP_W-1:0] query_setup,
  output logic rb_valid,
  output logic [matrix_setup_pkg::SETUP_W-1:0] rb_setup,
  output logic [1:0] rb_style,
  output logic rb_per_talk,
  output logic rb_closed_only,
  input wire logic col_valid,
  input wire logic [7:0] col_bits,
  input wire logic [matrix_setup_pkg::ROW_W-1:0] col_row,
  output logic enc_valid,
  output logic enc_pair,
  output logic [7:0] enc_hi,
  output logic [7:0] enc_lo
);

  localparam int SW = matrix_setup_pkg::SETUP_W;
  localparam int AW = matrix_setup_pkg::ADDR_W;
  localparam int DW = matrix_setup_pkg::DATA_W;
  localparam logic [SW-1:0] MAX_IDX = SW'(MAX_SETUP);
  localparam logic [SW-1:0] FIRST_STORED = 7'h01;

  if (MAX_SETUP < 1 || MAX_SETUP > (2 ** SW) - 1) begin : g_bad
    $error("MAX_SETUP does not fit the setup index");
  end

  typedef struct packed {
    logic [SW-1:0] edit_ptr;
    logic trig_en;
    logic [matrix_setup_pkg::FMT_W-1:0] fmt;
    logic [SW-1:0] trig_idx;
    logic reject;
    logic aw_got;
    logic w_got;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic wstrb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [DW-1:0] rdata;
    logic relay_we;
    logic mem_we;
    logic [SW-1:0] xp_setup;
    logic [matrix_setup_pkg::ROW_W-1:0] xp_row;
    logic [matrix_setup_pkg::COL_W-1:0] xp_col;
    logic xp_close;
    logic recall_stb;
    logic [SW-1:0] recall_setup;
    logic rb_valid;
    logic [SW-1:0] rb_setup;
    logic [1:0] rb_style;
    logic rb_per_talk;
    logic rb_closed_only;
    logic enc_valid;
    logic enc_pair;
    logic [7:0] enc_hi;
    logic [7:0] enc_lo;
  } state_t;

  state_t s;
  state_t n;
  logic ext_rise;
  logic wr_fire;
  logic dflt;
  logic trig_accept;
  matrix_setup_pkg::rb_style_t style;
  logic [SW-1:0] idx_next;

  trig_edge_sync #(
    .STAGES(matrix_setup_pkg::SYNC_STAGES)
  ) u_ext_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(ext_trigger_pin),
    .rise(ext_rise)
  );

  //////////////////////////////////////////////////////////////////////////////
  assign wr_fire = s.aw_got & s.w_got & ~s.bvalid;
  assign dflt = dev_clear | (wr_fire & s.wstrb0 & (s.waddr == matrix_setup_pkg::CONTROL_OFS)
                & s.wdata[matrix_setup_pkg::CTRL_RESTORE_BIT]);
  assign trig_accept = s.trig_en & (ext_rise | bus_trigger);
  assign style = matrix_setup_pkg::style_of(s.fmt);
  // The index wraps from the last stored setup back to the first one.
  assign idx_next = (s.trig_idx >= MAX_IDX) ? FIRST_STORED : SW'(s.trig_idx + 7'h01);

  always_comb begin
    n = s;
    n.relay_we = 1'b0;
    n.mem_we = 1'b0;
    n.recall_stb = 1'b0;
    n.rb_valid = 1'b0;
    n.enc_valid = 1'b0;

    // Write address and data are taken independently and joined here.
    if (s_axi_awvalid && s.awready) begin
      n.aw_got = 1'b1;
      n.waddr = {s_axi_awaddr[AW-1:2], 2'b00};
    end
    if (s_axi_wvalid && s.wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb0 = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s.wdata[matrix_setup_pkg::CTRL_CLR_REJECT_BIT] && wr_fire && s.wstrb0
        && s.waddr == matrix_setup_pkg::CONTROL_OFS) begin
      n.reject = 1'b0;
    end
    if (wr_fire) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = matrix_setup_pkg::RESP_OKAY;
      // A write without the low byte lane changes nothing.
      case (s.waddr)
        matrix_setup_pkg::EDIT_PTR_OFS: begin
          if (s.wstrb0 && s.wdata > DW'(MAX_SETUP)) begin
            n.reject = 1'b1;
          end else if (s.wstrb0) begin
            n.edit_ptr = s.wdata[SW-1:0];
          end
        end
        matrix_setup_pkg::TRIG_EN_OFS: begin
          if (s.wstrb0 && s.wdata > 32'h0000_0001) begin
            n.reject = 1'b1;
          end else if (s.wstrb0) begin
            n.trig_en = s.wdata[0];
          end
        end
        matrix_setup_pkg::RB_FORMAT_OFS: begin
          if (s.wstrb0 && s.wdata > 32'h0000_0007) begin
            n.reject = 1'b1;
          end else if (s.wstrb0) begin
            n.fmt = s.wdata[matrix_setup_pkg::FMT_W-1:0];
          end
        end
        matrix_setup_pkg::CONTROL_OFS: begin
        end
        default: begin
          n.bresp = matrix_setup_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (dflt) begin
      n.edit_ptr = matrix_setup_pkg::EDIT_PTR_RST;
      n.trig_en = matrix_setup_pkg::TRIG_EN_RST;
      n.fmt = matrix_setup_pkg::RB_FORMAT_RST;
    end

    ////////////////////////////////////////////////////////////////////////////
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp = matrix_setup_pkg::RESP_OKAY;
      n.rdata = '0;
      case ({s_axi_araddr[AW-1:2], 2'b00})
        matrix_setup_pkg::EDIT_PTR_OFS: n.rdata[SW-1:0] = s.edit_ptr;
        matrix_setup_pkg::TRIG_EN_OFS: n.rdata[0] = s.trig_en;
        matrix_setup_pkg::RB_FORMAT_OFS: n.rdata[matrix_setup_pkg::FMT_W-1:0] = s.fmt;
        matrix_setup_pkg::CONTROL_OFS: n.rdata = '0;
        matrix_setup_pkg::TRIG_INDEX_OFS: n.rdata[SW-1:0] = s.trig_idx;
        matrix_setup_pkg::STATUS_OFS: begin
          n.rdata[matrix_setup_pkg::STAT_REJECT_BIT] = s.reject;
          n.rdata[matrix_setup_pkg::STAT_STYLE_LSB +: 2] = style;
          n.rdata[matrix_setup_pkg::STAT_PER_TALK_BIT] = s.fmt[0]
            & (style != matrix_setup_pkg::STYLE_INSPECT);
          n.rdata[matrix_setup_pkg::STAT_CLOSED_BIT] = (style == matrix_setup_pkg::STYLE_INSPECT);
        end
        default: n.rresp = matrix_setup_pkg::RESP_SLVERR;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // The trigger path never touches the edit pointer.
    if (trig_accept) begin
      n.trig_idx = idx_next;
      n.recall_stb = 1'b1;
      n.recall_setup = idx_next;
    end

    // Commands go straight to relays or stored bits; nothing else is needed.
    if (xp_valid) begin
      n.relay_we = (s.edit_ptr == matrix_setup_pkg::LIVE_SETUP);
      n.mem_we = (s.edit_ptr != matrix_setup_pkg::LIVE_SETUP);
      n.xp_setup = s.edit_ptr;
      n.xp_row = xp_row;
      n.xp_col = xp_col;
      n.xp_close = xp_close;
    end

    if (setup_readback_query) begin
      n.rb_valid = 1'b1;
      n.rb_setup = query_setup;
      n.rb_style = style;
      n.rb_per_talk = s.fmt[0] & (style != matrix_setup_pkg::STYLE_INSPECT);
      n.rb_closed_only = (style == matrix_setup_pkg::STYLE_INSPECT);
    end

    if (col_valid) begin
      n.enc_pair = 1'b0;
      n.enc_lo = 8'h00;
      n.enc_valid = 1'b1;
      case (style)
        matrix_setup_pkg::STYLE_FULL: begin
          n.enc_hi = col_bits[col_row] ? matrix_setup_pkg::CHAR_CLOSED
                                       : matrix_setup_pkg::CHAR_OPEN;
        end
        matrix_setup_pkg::STYLE_INSPECT: begin
          n.enc_valid = col_bits[col_row];
          n.enc_hi = 8'(matrix_setup_pkg::CHAR_ROW_A + {5'h00, col_row});
        end
        matrix_setup_pkg::STYLE_CONDENSED: begin
          n.enc_pair = 1'b1;
          n.enc_hi = matrix_setup_pkg::hex_char(col_bits[7:4]);
          n.enc_lo = matrix_setup_pkg::hex_char(col_bits[3:0]);
        end
        default: begin
          n.enc_hi = col_bits;
        end
      endcase
    end

    n.awready = ~n.aw_got & ~n.bvalid;
    n.wready = ~n.w_got & ~n.bvalid;
    n.arready = ~n.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.edit_ptr <= matrix_setup_pkg::EDIT_PTR_RST;
      s.trig_en <= matrix_setup_pkg::TRIG_EN_RST;
      s.fmt <= matrix_setup_pkg::RB_FORMAT_RST;
      s.trig_idx <= matrix_setup_pkg::TRIG_INDEX_RST;
    end else begin
      s <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = s.rdata;
  assign relay_we = s.relay_we;
  assign mem_we = s.mem_we;
  assign xp_setup = s.xp_setup;
  assign xp_row_out = s.xp_row;
  assign xp_col_out = s.xp_col;
  assign xp_close_out = s.xp_close;
  assign recall_stb = s.recall_stb;
  assign recall_setup = s.recall_setup;
  assign rb_valid = s.rb_valid;
  assign rb_setup = s.rb_setup;
  assign rb_style = s.rb_style;
  assign rb_per_talk = s.rb_per_talk;
  assign rb_closed_only = s.rb_closed_only;
  assign enc_valid = s.enc_valid;
  assign enc_pair = s.enc_pair;
  assign enc_hi = s.enc_hi;
  assign enc_lo = s.enc_lo;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_defaults_apply: assert property (dev_clear |=> s.edit_ptr == 7'h00 && !s.trig_en
    && s.fmt == 3'h0) else $error("defaults not applied after device clear");
  a_trig_disabled: assert property (!s.trig_en |=> !s.recall_stb)
    else $error("trigger acted while disabled");
  a_trig_sources: assert property (s.trig_en && (ext_rise || bus_trigger) |=> s.recall_stb)
    else $error("enabled trigger was not accepted");
  a_trig_step: assert property (s.recall_stb |-> s.recall_setup == s.trig_idx
    && s.trig_idx == (($past(s.trig_idx) >= MAX_IDX) ? 7'h01 : $past(s.trig_idx) + 7'h01))
    else $error("trigger index step or recall setup wrong");
  a_edit_indep: assert property (!$stable(s.edit_ptr) |-> $past(wr_fire || dflt))
    else $error("edit pointer moved without a write or default");
  a_xp_route: assert property (xp_valid |=> (s.relay_we == ($past(s.edit_ptr) == 7'h00))
    && (s.mem_we != s.relay_we) && s.xp_setup == $past(s.edit_ptr))
    else $error("crosspoint command routed to wrong setup");
  a_reject_keep: assert property (wr_fire && s.wstrb0 && !dflt
    && s.waddr == matrix_setup_pkg::EDIT_PTR_OFS && s.wdata > DW'(MAX_SETUP)
    |=> $stable(s.edit_ptr) && s.reject) else $error("out of range edit pointer accepted");
  a_rb_style: assert property (setup_readback_query |=> s.rb_valid
    && s.rb_closed_only == ($past(s.fmt[2:1]) == 2'b01) && s.rb_style == $past(s.fmt[2:1]))
    else $error("readback style does not follow format");
  a_full_chars: assert property (col_valid && s.fmt[2:1] == 2'b00 |=> s.enc_valid
    && (s.enc_hi == 8'h58 || s.enc_hi == 8'h2D)) else $error("full format character wrong");
  a_bresp_hold: assert property (s.bvalid && !s_axi_bready |=> s.bvalid && $stable(s.bresp))
    else $error("write response dropped before taken");

  c_trig_recall: cover property (s.trig_en ##1 s.recall_stb);
  c_stored_close: cover property (xp_valid && s.edit_ptr != 7'h00 ##1 s.mem_we);
  c_reject: cover property ($rose(s.reject));
  c_read_done: cover property (s.rvalid && s_axi_rready);

endmodule : matrix_setup_ctrl

// [tb/axi_host_model.sv]
`timescale 1ns/10ps
// Register bus master: one write and one read at a time, and it waits as long as the slave needs.
module axi_host_model (
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Handshakes are judged at the falling edge, where slave outputs are settled, and acted on
  // right after the rising edge that completes them, so no release races the slave.
  // The write response is accepted one cycle after it shows, so the slave must hold it meanwhile.
  task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b, v;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid && bready;
      v = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
      else if (v) bready <= 1'b1;
    end
  endtask : write
  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, rd;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rd = 1'b0;
    while (!rd) begin
      @(negedge aclk);
      ar = arvalid && arready;
      rd = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
      if (rd) rready <= 1'b0;
    end
  endtask : read
endmodule : axi_host_model

// [tb/matrix_setup_command_state_bench.sv]
`timescale 1ns/10ps
`define CHECK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin failures++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module matrix_setup_command_state_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr, col_bits, enc_hi, enc_lo;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rb_style;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic dev_clear, bus_trigger, ext_pin, xp_valid, xp_close, relay_we, mem_we, xp_close_out;
  logic recall_stb, query, rb_valid, rb_per_talk, rb_closed_only, col_valid, enc_valid, enc_pair;
  logic [2:0] xp_row, xp_row_out, col_row;
  logic [8:0] xp_col, xp_col_out;
  logic [6:0] xp_setup, recall_setup, query_setup, rb_setup;
  int failures = 0;
  int checks_done = 0;
  always #25 aclk = ~aclk;
  axi_host_model hst (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  matrix_setup_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .dev_clear(dev_clear), .bus_trigger(bus_trigger),
    .ext_trigger_pin(ext_pin), .xp_valid(xp_valid), .xp_close(xp_close), .xp_row(xp_row),
    .xp_col(xp_col), .relay_we(relay_we), .mem_we(mem_we), .xp_setup(xp_setup),
    .xp_row_out(xp_row_out), .xp_col_out(xp_col_out), .xp_close_out(xp_close_out),
    .recall_stb(recall_stb), .recall_setup(recall_setup), .setup_readback_query(query),
    .query_setup(query_setup), .rb_valid(rb_valid), .rb_setup(rb_setup), .rb_style(rb_style),
    .rb_per_talk(rb_per_talk), .rb_closed_only(rb_closed_only), .col_valid(col_valid),
    .col_bits(col_bits), .col_row(col_row), .enc_valid(enc_valid), .enc_pair(enc_pair),
    .enc_hi(enc_hi), .enc_lo(enc_lo));
  //////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    hst.write(a, d, r);
  endtask : wr
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] d;
    logic [1:0] r;
    hst.read(a, d, r);
    `CHECK(nm, ex, d)
  endtask : rchk
  task automatic xp_cmd(input logic [6:0] setup, input logic live);
    @(posedge aclk);
    xp_valid <= 1'b1;
    xp_close <= ~xp_close;
    xp_row <= xp_row + 3'h3;
    xp_col <= xp_col + 9'h0A7;
    @(posedge aclk);
    xp_valid <= 1'b0;
    @(negedge aclk);
    `CHECK("relay_we", live, relay_we)
    `CHECK("mem_we", !live, mem_we)
    `CHECK("xp_setup", setup, xp_setup)
    `CHECK("xp fields", {xp_close, xp_row, xp_col}, {xp_close_out, xp_row_out, xp_col_out})
  endtask : xp_cmd
  task automatic bus_trig(input logic ex, input logic [6:0] idx);
    @(posedge aclk);
    bus_trigger <= 1'b1;
    @(posedge aclk);
    bus_trigger <= 1'b0;
    @(negedge aclk);
    `CHECK("recall_stb", ex, recall_stb)
    if (ex) `CHECK("recall_setup", idx, recall_setup)
  endtask : bus_trig
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults;
    logic [31:0] d;
    logic [1:0] r;
    rchk("edit_ptr", matrix_setup_pkg::EDIT_PTR_OFS, 32'h0000_0000);
    rchk("trig_en", matrix_setup_pkg::TRIG_EN_OFS, 32'h0000_0000);
    rchk("rb_format", matrix_setup_pkg::RB_FORMAT_OFS, 32'h0000_0000);
    rchk("trig_index", matrix_setup_pkg::TRIG_INDEX_OFS, 32'h0000_0000);
    hst.read(8'h40, d, r);
    `CHECK("unmapped rresp", matrix_setup_pkg::RESP_SLVERR, r)
    hst.write(8'h40, 32'h0000_0001, r);
    `CHECK("unmapped bresp", matrix_setup_pkg::RESP_SLVERR, r)
    $display("test defaults done");
  endtask : t_defaults
  task automatic t_edit;
    logic [1:0] r;
    wr(matrix_setup_pkg::EDIT_PTR_OFS, 32'h0000_0064);
    rchk("edit 100", matrix_setup_pkg::EDIT_PTR_OFS, 32'h0000_0064);
    hst.write(matrix_setup_pkg::EDIT_PTR_OFS, 32'h0000_0065, r);
    `CHECK("reject bresp", matrix_setup_pkg::RESP_OKAY, r)
    rchk("edit kept", matrix_setup_pkg::EDIT_PTR_OFS, 32'h0000_0064);
    rchk("reject flag", matrix_setup_pkg::STATUS_OFS, 32'h0000_0001);
    wr(matrix_setup_pkg::CONTROL_OFS, 32'h0000_0002);
    rchk("reject clear", matrix_setup_pkg::STATUS_OFS, 32'h0000_0000);
    xp_cmd(7'h64, 1'b0);
    xp_cmd(7'h64, 1'b0);
    wr(matrix_setup_pkg::EDIT_PTR_OFS, 32'h0000_0000);
    xp_cmd(7'h00, 1'b1);
    $display("test edit pointer done");
  endtask : t_edit
  task automatic t_trigger;
    int seen;
    wr(matrix_setup_pkg::EDIT_PTR_OFS, 32'h0000_0007);
    bus_trig(1'b0, 7'h00);
    wr(matrix_setup_pkg::TRIG_EN_OFS, 32'h0000_0002);
    rchk("trig_en kept", matrix_setup_pkg::TRIG_EN_OFS, 32'h0000_0000);
    wr(matrix_setup_pkg::TRIG_EN_OFS, 32'h0000_0001);
    bus_trig(1'b1, 7'h01);
    rchk("trig_index", matrix_setup_pkg::TRIG_INDEX_OFS, 32'h0000_0001);
    rchk("edit unmoved", matrix_setup_pkg::EDIT_PTR_OFS, 32'h0000_0007);
    // Triggers go off before the source moves to the external pin.
    wr(matrix_setup_pkg::TRIG_EN_OFS, 32'h0000_0000);
    @(posedge aclk);
    ext_pin <= 1'b1;
    seen = 0;
    repeat (8) begin @(negedge aclk); seen += int'(recall_stb); end
    `CHECK("ext while off", 0, seen)
    @(posedge aclk);
    ext_pin <= 1'b0;
    wr(matrix_setup_pkg::TRIG_EN_OFS, 32'h0000_0001);
    @(posedge aclk);
    ext_pin <= 1'b1;
    repeat (8) begin @(negedge aclk); seen += int'(recall_stb); end
    `CHECK("ext trigger", 1, seen)
    `CHECK("ext index", 7'h02, recall_setup)
    $display("test trigger done");
  endtask : t_trigger
  task automatic t_formats;
    logic [1:0] st;
    logic [2:0] f;
    logic [7:0] hi;
    for (int i = 0; i < 8; i++) begin
      f = 3'(i);
      st = f[2:1];
      wr(matrix_setup_pkg::RB_FORMAT_OFS, 32'(i));
      @(posedge aclk);
      query <= 1'b1;
      query_setup <= 7'(i * 13);
      @(posedge aclk);
      query <= 1'b0;
      @(negedge aclk);
      `CHECK("rb_valid", 1'b1, rb_valid)
      `CHECK("rb_setup", 7'(i * 13), rb_setup)
      `CHECK("rb_style", st, rb_style)
      `CHECK("rb_per_talk", (f == 3'h3) ? 1'b0 : f[0], rb_per_talk)
      `CHECK("rb_closed_only", st == 2'h1, rb_closed_only)
      for (int row = 2; row > 0; row--) begin
        @(posedge aclk);
        col_valid <= 1'b1;
        col_bits <= 8'hA5;
        col_row <= 3'(row);
        @(posedge aclk);
        col_valid <= 1'b0;
        @(negedge aclk);
        `CHECK("enc_valid", !(st == 2'h1 && row == 1), enc_valid)
        hi = (st == 2'h0) ? ((row == 2) ? 8'h58 : 8'h2D) : (st == 2'h1) ? 8'h43 :
          (st == 2'h2) ? 8'h41 : 8'hA5;
        if (enc_valid === 1'b1) `CHECK("enc_hi", hi, enc_hi)
        `CHECK("enc_pair", st == 2'h2, enc_pair)
        if (st == 2'h2) `CHECK("enc_lo", 8'h35, enc_lo)
      end
    end
    wr(matrix_setup_pkg::RB_FORMAT_OFS, 32'h0000_0008);
    rchk("format kept", matrix_setup_pkg::RB_FORMAT_OFS, 32'h0000_0007);
    $display("test formats done");
  endtask : t_formats
  task automatic t_restore;
    for (int k = 0; k < 2; k++) begin
      wr(matrix_setup_pkg::EDIT_PTR_OFS, 32'h0000_0032);
      wr(matrix_setup_pkg::RB_FORMAT_OFS, 32'h0000_0005);
      if (k == 0) wr(matrix_setup_pkg::CONTROL_OFS, 32'h0000_0001);
      else begin
        @(posedge aclk);
        dev_clear <= 1'b1;
        @(posedge aclk);
        dev_clear <= 1'b0;
      end
      rchk("edit default", matrix_setup_pkg::EDIT_PTR_OFS, 32'h0000_0000);
      rchk("trig default", matrix_setup_pkg::TRIG_EN_OFS, 32'h0000_0000);
      rchk("format default", matrix_setup_pkg::RB_FORMAT_OFS, 32'h0000_0000);
      rchk("index kept", matrix_setup_pkg::TRIG_INDEX_OFS, 32'h0000_0002);
      wr(matrix_setup_pkg::TRIG_EN_OFS, 32'h0000_0001);
    end
    $display("test restore done");
  endtask : t_restore
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {dev_clear, bus_trigger, ext_pin, xp_valid, xp_close, query, col_valid} = '0;
    {xp_row, xp_col, query_setup, col_bits, col_row} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_defaults;
    t_edit;
    t_trigger;
    t_formats;
    t_restore;
    finish_test;
  end
  // The whole sequence needs well under two thousand cycles; forty thousand means a hang.
  initial begin
    #2000000;
    failures++;
    finish_test;
  end
endmodule : matrix_setup_command_state_bench
